/* core/serial_memory_cfg.svh */
// Operation
// - array is 128 sectors of 128 KB, reached by 24-bit byte addresses
// - array splits into 64-byte pages, the unit of one page program
// - page write either clears bits only or alters bits both ways
// - erase sets every bit of one addressed sector to one
// - sector n spans n times 20000h up to the next boundary minus one
// - first input bit is taken on the first rising clock after select falls
// - opcode arrives msb first, each bit latched on a rising clock edge
// - every transaction opens with the opcode, then its fixed byte counts
// - read opcodes end in an output phase that select may end at any bit
// - write-type opcodes execute only if select rises on a byte boundary
// - array access is ignored while an internal write cycle runs
// - opcode 06h sets the write latch and carries no further bytes
// - 01h takes exactly one data byte, 04h takes no further bytes
// - 03h takes three address bytes, then returns data while selected
// - 0Bh takes three address bytes and a dummy, then returns data
// - 05h repeats the status byte, 9Fh returns up to three id bytes
// - 02h, 22h, D1h take three address bytes then 1 to 64 data bytes
// - D8h takes three address bytes naming the sector to erase
// - while busy only status read is accepted, all others ignored
// - write latch clears at reset and on write disable, status write, program, erase
// - each output bit is driven at the falling clock edge
`ifndef SERIAL_MEMORY_CFG_SVH
`define SERIAL_MEMORY_CFG_SVH

`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_ID        8'h9f
`define OP_READ_STATUS    8'h05
`define OP_WRITE_STATUS   8'h01
`define OP_READ_DATA      8'h03
`define OP_QUICK_READ     8'h0b
`define OP_PROGRAM_LEGACY 8'h02
`define OP_PROGRAM_ALTER  8'h22
`define OP_PROGRAM_ONES   8'hd1
`define OP_BLOCK_WIPE     8'hd8

`define ADDR_BYTES        2'h3
`define SECTOR_COUNT      128
`define SECTOR_BITS       17
`define PAGE_BYTES        7'h40
`define STATUS_WR_MASK    8'hfc
`define ID_BYTES          2'h3

`define CLK_PERIOD_NS     100
`define STATUS_WR_TIME_NS 1000
`define STATUS_WR_CYCLES  (((`STATUS_WR_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

/* core/serial_memory_pkg.sv */
package serial_memory_pkg;

	typedef enum logic [2:0] {
		AK_READ,
		AK_PROGRAM,
		AK_BITWRITE,
		AK_PROGRAM_ONES,
		AK_SECTOR_ERASE
	} array_kind_t;

	typedef struct packed {
		logic        valid;
		array_kind_t kind;
		logic [23:0] addr;
		logic [7:0]  data;
		logic        last;
	} array_cmd_t;

	typedef struct packed {
		logic       rd_valid;
		logic [7:0] rd_data;
		logic       done;
	} array_rsp_t;

	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic in_bit_line;
	} spi_pins_t;

endpackage

/* core/page_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

module page_buffer (
	// clock
	input  wire logic       clk_sys,
	// write side
	input  wire logic       wr_en,
	input  wire logic [5:0] wr_col,
	input  wire logic [7:0] wr_data,
	// read side, one cycle latency
	input  wire logic [5:0] rd_col,
	output logic      [7:0] rd_data
);

	// one page of staged bytes; contents need no reset, only written columns are replayed
	logic [7:0] mem [0:63];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_col] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_data <= mem[rd_col];
	end

endmodule

`default_nettype wire

/* core/serial_memory_command_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_memory_cfg.svh"

module serial_memory_command_port #(
	parameter logic [7:0] ID_BYTE0 = 8'h5a, // arbitrary
	parameter logic [7:0] ID_BYTE1 = 8'h3c, // arbitrary
	parameter logic [7:0] ID_BYTE2 = 8'h18  // arbitrary
) (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	// serial pins
	input  wire serial_memory_pkg::spi_pins_t  spi_pins,
	output logic                               out_bit_line,
	output logic                               out_oe_n,
	// array side
	output serial_memory_pkg::array_cmd_t      array_cmd,
	input  wire serial_memory_pkg::array_rsp_t array_rsp,
	// status
	output logic                               write_latch_flag,
	output logic                               write_busy_flag
);
	import serial_memory_pkg::*;

	typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_DONE, ST_OUT, ST_IGNORE} state_t;

	spi_pins_t   sync1_reg, sync2_reg, prev_reg;
	state_t      state_reg;
	logic [2:0]  bit_cnt_reg;
	logic [6:0]  shift_reg;
	logic [7:0]  opcode_reg;
	logic [1:0]  addr_cnt_reg;
	logic [23:0] addr_reg;
	logic [5:0]  col_reg;
	logic [6:0]  wcount_reg;
	logic [7:0]  status_wdata_reg;
	logic [7:0]  pre_reg;
	logic [6:0]  out_shift_reg;
	logic [2:0]  out_cnt_reg;
	logic [1:0]  id_idx_reg;
	logic [5:0]  st_bits_reg;
	logic [3:0]  timer_reg;
	logic [6:0]  prog_left_reg;
	logic [5:0]  prog_col_reg;
	logic        pend_reg, pend_last_reg;
	logic [5:0]  pend_col_reg;
	logic [7:0]  buf_rdata;

	logic        sclk_rise, sclk_fall, sel_rise, byte_done, commit_ok, rd_first, rd_next, buf_we;
	logic [7:0]  in_byte;
	logic [7:0]  status_byte;

	function automatic logic is_prog(input logic [7:0] op);
		return op == `OP_PROGRAM_LEGACY || op == `OP_PROGRAM_ALTER || op == `OP_PROGRAM_ONES;
	endfunction

	function automatic array_kind_t prog_kind(input logic [7:0] op);
		unique case (op)
			`OP_PROGRAM_ALTER: return AK_BITWRITE;
			`OP_PROGRAM_ONES:  return AK_PROGRAM_ONES;
			default:           return AK_PROGRAM;
		endcase
	endfunction

	// opcode decode; gated by busy and by the write latch
	function automatic state_t decode(input logic [7:0] op, input logic busy, input logic latch);
		if (busy && op != `OP_READ_STATUS) begin
			return ST_IGNORE;
		end
		unique case (op)
			`OP_WRITE_ENABLE, `OP_WRITE_DISABLE: return ST_DONE;
			`OP_READ_STATUS, `OP_READ_ID:        return ST_OUT;
			`OP_READ_DATA, `OP_QUICK_READ:       return ST_ADDR;
			`OP_WRITE_STATUS:                    return latch ? ST_WDATA : ST_IGNORE;
			`OP_PROGRAM_LEGACY, `OP_PROGRAM_ALTER, `OP_PROGRAM_ONES, `OP_BLOCK_WIPE:
				return latch ? ST_ADDR : ST_IGNORE;
			default:                             return ST_IGNORE;
		endcase
	endfunction

	// pins cross into clk_sys through two flops; edges found against a third
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_reg <= 3'h4;
			sync2_reg <= 3'h4;
			prev_reg  <= 3'h4;
		end else begin
			sync1_reg <= spi_pins;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign sclk_rise   = !sync2_reg.sel_n && sync2_reg.sclk && !prev_reg.sclk;
	assign sclk_fall   = !sync2_reg.sel_n && !sync2_reg.sclk && prev_reg.sclk;
	assign sel_rise    = sync2_reg.sel_n && !prev_reg.sel_n;
	assign in_byte     = {shift_reg, sync2_reg.in_bit_line};
	assign byte_done   = sclk_rise && bit_cnt_reg == 3'h7;
	assign status_byte = {st_bits_reg, write_latch_flag, write_busy_flag};
	assign buf_we      = byte_done && state_reg == ST_WDATA && is_prog(opcode_reg);
	assign rd_first    = byte_done && ((state_reg == ST_ADDR && addr_cnt_reg == 2'h2 &&
		opcode_reg == `OP_READ_DATA) || state_reg == ST_DUMMY);
	assign rd_next     = sclk_fall && state_reg == ST_OUT && out_cnt_reg == 3'h0 &&
		(opcode_reg == `OP_READ_DATA || opcode_reg == `OP_QUICK_READ);
	// write-type opcodes run only when select rises on a byte boundary
	assign commit_ok   = sel_rise && bit_cnt_reg == 3'h0 && (state_reg == ST_DONE ||
		(state_reg == ST_WDATA && is_prog(opcode_reg) && wcount_reg != 7'h0));

	// input shifter and instruction sequencing
	always_ff @(posedge clk_sys) begin
		if (sys_rst || sync2_reg.sel_n) begin
			state_reg   <= ST_CMD;
			bit_cnt_reg <= 3'h0;
		end else if (sclk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				unique case (state_reg)
					ST_CMD:    state_reg <= decode(in_byte, write_busy_flag, write_latch_flag);
					ST_ADDR: begin
						if (addr_cnt_reg == 2'h2) begin
							if (opcode_reg == `OP_QUICK_READ) begin
								state_reg <= ST_DUMMY;
							end else if (opcode_reg == `OP_READ_DATA) begin
								state_reg <= ST_OUT;
							end else if (opcode_reg == `OP_BLOCK_WIPE) begin
								state_reg <= ST_DONE;
							end else begin
								state_reg <= ST_WDATA;
							end
						end
					end
					ST_DUMMY:  state_reg <= ST_OUT;
					ST_WDATA:  state_reg <= (opcode_reg == `OP_WRITE_STATUS) ? ST_DONE : ST_WDATA;
					ST_DONE:   state_reg <= ST_IGNORE;
					ST_OUT, ST_IGNORE: state_reg <= state_reg;
				endcase
			end
		end
	end

	// byte assembly, address and page column capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shift_reg     <= 7'h0;
			opcode_reg    <= 8'h0;
			addr_cnt_reg  <= 2'h0;
			addr_reg      <= 24'h0;
			col_reg       <= 6'h0;
			wcount_reg    <= 7'h0;
			status_wdata_reg <= 8'h0;
		end else if (sclk_rise) begin
			shift_reg <= in_byte[6:0];
			if (bit_cnt_reg == 3'h7) begin
				if (state_reg == ST_CMD) begin
					opcode_reg   <= in_byte;
					addr_cnt_reg <= 2'h0;
					wcount_reg   <= 7'h0;
				end
				if (state_reg == ST_ADDR) begin
					addr_reg     <= {addr_reg[15:0], in_byte};
					addr_cnt_reg <= addr_cnt_reg + 2'h1;
					col_reg      <= in_byte[5:0];
				end
				if (state_reg == ST_WDATA) begin
					status_wdata_reg <= in_byte;
					col_reg       <= col_reg + 6'h1;
					if (wcount_reg != `PAGE_BYTES) begin
						wcount_reg <= wcount_reg + 7'h1;
					end
				end
			end
		end else if (rd_next) begin
			addr_reg <= addr_reg + 24'h1;
		end
	end

	page_buffer u_page_buffer (
		.clk_sys (clk_sys),
		.wr_en   (buf_we),
		.wr_col  (col_reg),
		.wr_data (in_byte),
		.rd_col  (prog_col_reg),
		.rd_data (buf_rdata)
	);

	// next output byte is staged ahead of the falling edge that needs it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pre_reg    <= 8'h0;
			id_idx_reg <= 2'h0;
		end else begin
			if (state_reg != ST_OUT) begin
				id_idx_reg <= 2'h0;
			end else if (sclk_fall && out_cnt_reg == 3'h0 && id_idx_reg != `ID_BYTES) begin
				id_idx_reg <= id_idx_reg + 2'h1;
			end
			if (opcode_reg == `OP_READ_STATUS) begin
				pre_reg <= status_byte;
			end else if (opcode_reg == `OP_READ_ID) begin
				unique case (id_idx_reg)
					2'h0:    pre_reg <= ID_BYTE0;
					2'h1:    pre_reg <= ID_BYTE1;
					2'h2:    pre_reg <= ID_BYTE2;
					default: pre_reg <= 8'h0;
				endcase
			end else if (array_rsp.rd_valid) begin
				pre_reg <= array_rsp.rd_data;
			end
		end
	end

	// output shifter, shifts only on falling clock; floats and clears once select is high or state leaves ST_OUT
	always_ff @(posedge clk_sys) begin
		// float as soon as select is seen high, not a cycle later when the state drops
		if (sys_rst || sync2_reg.sel_n || state_reg != ST_OUT) begin
			out_oe_n      <= 1'h1;
			out_bit_line  <= 1'h0;
			out_shift_reg <= 7'h0;
			out_cnt_reg   <= 3'h0;
		end else if (sclk_fall) begin
			out_oe_n    <= 1'h0;
			out_cnt_reg <= out_cnt_reg + 3'h1;
			if (out_cnt_reg == 3'h0) begin
				out_bit_line  <= pre_reg[7];
				out_shift_reg <= pre_reg[6:0];
			end else begin
				out_bit_line  <= out_shift_reg[6];
				out_shift_reg <= {out_shift_reg[5:0], 1'h0};
			end
		end
	end

	// write latch, busy and status bits; nothing here can start while busy
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			write_latch_flag <= 1'h0;
			write_busy_flag  <= 1'h0;
			st_bits_reg      <= 6'h0;
			timer_reg        <= 4'h0;
		end else if (commit_ok) begin
			write_latch_flag <= opcode_reg == `OP_WRITE_ENABLE;
			write_busy_flag  <= opcode_reg != `OP_WRITE_ENABLE && opcode_reg != `OP_WRITE_DISABLE;
			if (opcode_reg == `OP_WRITE_STATUS) begin
				st_bits_reg <= status_wdata_reg[7:2] & 6'(`STATUS_WR_MASK >> 2);
				timer_reg   <= 4'(`STATUS_WR_CYCLES);
			end
		end else if (timer_reg != 4'h0) begin
			timer_reg <= timer_reg - 4'h1;
			if (timer_reg == 4'h1) begin
				write_busy_flag <= 1'h0;
			end
		end else if (array_rsp.done) begin
			write_busy_flag <= 1'h0;
		end
	end

	// program engine replays the staged page one byte per cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prog_left_reg <= 7'h0;
			prog_col_reg  <= 6'h0;
			pend_reg      <= 1'h0;
			pend_col_reg  <= 6'h0;
			pend_last_reg <= 1'h0;
		end else if (commit_ok && is_prog(opcode_reg)) begin
			prog_left_reg <= wcount_reg;
			prog_col_reg  <= col_reg - 6'(wcount_reg);
			pend_reg      <= 1'h0;
		end else begin
			pend_reg      <= prog_left_reg != 7'h0;
			pend_col_reg  <= prog_col_reg;
			pend_last_reg <= prog_left_reg == 7'h1;
			if (prog_left_reg != 7'h0) begin
				prog_left_reg <= prog_left_reg - 7'h1;
				prog_col_reg  <= prog_col_reg + 6'h1;
			end
		end
	end

	// array command port
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			array_cmd <= '0;
		end else begin
			array_cmd <= '0;
			if (pend_reg) begin
				array_cmd <= {1'h1, prog_kind(opcode_reg), addr_reg[23:6], pend_col_reg, buf_rdata,
					pend_last_reg};
			end else if (commit_ok && opcode_reg == `OP_BLOCK_WIPE) begin
				array_cmd <= {1'h1, AK_SECTOR_ERASE, addr_reg[23:`SECTOR_BITS], 17'h0, 8'hff, 1'h1};
			end else if (rd_first) begin
				array_cmd <= {1'h1, AK_READ, (state_reg == ST_DUMMY) ? addr_reg : {addr_reg[15:0], in_byte},
					8'h0, 1'h1};
			end else if (rd_next) begin
				array_cmd <= {1'h1, AK_READ, addr_reg + 24'h1, 8'h0, 1'h1};
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_float_when_idle;
		sync2_reg.sel_n |=> out_oe_n;
	endproperty
	a_float_when_idle: assert property (p_float_when_idle) else $error("output driven while deselected");

	property p_latch_set;
		commit_ok && opcode_reg == `OP_WRITE_ENABLE |=> write_latch_flag && !write_busy_flag;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("write enable did not set latch");

	property p_latch_clear;
		commit_ok && opcode_reg != `OP_WRITE_ENABLE |=> !write_latch_flag;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared on completion");

	property p_busy_filter;
		byte_done && state_reg == ST_CMD && write_busy_flag && in_byte != `OP_READ_STATUS |=> state_reg == ST_IGNORE;
	endproperty
	a_busy_filter: assert property (p_busy_filter) else $error("opcode accepted while busy");

	property p_boundary_reject;
		sel_rise && bit_cnt_reg != 3'h0 && !write_busy_flag |=> !write_busy_flag [*2];
	endproperty
	a_boundary_reject: assert property (p_boundary_reject) else $error("off-boundary write executed");

	property p_erase_aligned;
		array_cmd.valid && array_cmd.kind == AK_SECTOR_ERASE |-> array_cmd.addr[16:0] == 17'h0;
	endproperty
	a_erase_aligned: assert property (p_erase_aligned) else $error("erase address not sector aligned");

	property p_no_read_busy;
		array_cmd.valid && array_cmd.kind == AK_READ |-> !write_busy_flag;
	endproperty
	a_no_read_busy: assert property (p_no_read_busy) else $error("array read during write cycle");

	property p_first_bit_msb;
		sclk_fall && state_reg == ST_OUT && out_cnt_reg == 3'h0 |=> out_bit_line == $past(pre_reg[7]) && !out_oe_n;
	endproperty
	a_first_bit_msb: assert property (p_first_bit_msb) else $error("first output bit not msb");

	c_read_data:   cover property (rd_first ##[1:40] rd_next);
	c_program:     cover property (commit_ok && is_prog(opcode_reg) ##[1:80] array_cmd.last);
	c_status_poll: cover property (write_busy_flag && state_reg == ST_OUT && opcode_reg == `OP_READ_STATUS);

endmodule

`default_nettype wire

/* verification/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// clock
	input  wire logic                    clk_sys,
	// link pins
	output serial_memory_pkg::spi_pins_t pins,
	input  wire logic                    sdo
);
	import serial_memory_pkg::*;

	initial pins = '{sel_n: 1'b1, sclk: 1'b0, in_bit_line: 1'b0};

	// one link clock: fall and present, rise 4 cycles on, sample late in the high half
	task automatic bit_x(input logic b, output logic r);
		@(posedge clk_sys);
		pins.sclk        <= 1'b0;
		pins.in_bit_line <= b;
		repeat (4) @(posedge clk_sys);
		pins.sclk <= 1'b1;
		repeat (3) @(posedge clk_sys);
		r = sdo;
	endtask

	// idle input bits toggle so a stale level is never mistaken for data
	task automatic frame(input logic [7:0] tx[$], input int nrx, input int xbits, output logic [7:0] rx[$]);
		logic       r;
		logic [7:0] v;
		rx = {};
		@(posedge clk_sys);
		pins.sel_n <= 1'b0;
		foreach (tx[i]) for (int k = 7; k >= 0; k--) bit_x(tx[i][k], r);
		for (int k = 0; k < xbits; k++) bit_x(~pins.in_bit_line, r);
		for (int i = 0; i < nrx; i++) begin
			for (int k = 7; k >= 0; k--) begin
				bit_x(~pins.in_bit_line, r);
				v[k] = r;
			end
			rx.push_back(v);
		end
		@(posedge clk_sys);
		pins.sclk <= 1'b0;
		repeat (2) @(posedge clk_sys);
		pins.sel_n       <= 1'b1;
		pins.in_bit_line <= ~pins.in_bit_line;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

`default_nettype wire

/* verification/serial_memory_command_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_memory_cfg.svh"

module serial_memory_command_port_tb_top;
	import serial_memory_pkg::*;

	localparam logic [7:0] ID0 = 8'h81; // arbitrary
	localparam logic [7:0] ID1 = 8'h42; // arbitrary
	localparam logic [7:0] ID2 = 8'h24; // arbitrary

	logic       clk_sys;
	logic       sys_rst;
	spi_pins_t  spi_pins;
	logic       out_bit_line;
	logic       out_oe_n;
	logic       write_latch_flag;
	logic       write_busy_flag;
	array_cmd_t array_cmd;
	array_rsp_t array_rsp;
	wire logic  sdo = out_oe_n ? 1'bz : out_bit_line;
	array_cmd_t beats[$];
	logic [7:0] rx[$];
	int         done_dly = 40;
	int         cnt = 0;
	int         fails = 0;
	int         total_checks = 0;

	serial_memory_command_port #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2)) dut_u (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_pins(spi_pins), .out_bit_line(out_bit_line),
		.out_oe_n(out_oe_n), .array_cmd(array_cmd), .array_rsp(array_rsp),
		.write_latch_flag(write_latch_flag), .write_busy_flag(write_busy_flag));

	spi_host_model host_u (.clk_sys(clk_sys), .pins(spi_pins), .sdo(sdo));

	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] + 8'h11;
	endfunction

	// array stand-in: reads answer next cycle, writes finish done_dly cycles after the last beat
	always @(posedge clk_sys) begin
		array_rsp <= '0;
		if (array_cmd.valid === 1'b1) begin
			beats.push_back(array_cmd);
			if (array_cmd.kind == AK_READ)
				array_rsp <= '{rd_valid: 1'b1, rd_data: pat(array_cmd.addr), done: 1'b0};
			else if (array_cmd.last === 1'b1)
				cnt <= done_dly;
		end
		if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1)
				array_rsp.done <= 1'b1;
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic sf(input logic [7:0] tx[$], input int nrx, input int xb);
		host_u.frame(tx, nrx, xb, rx);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 2000 && write_busy_flag !== 1'b0; i++) @(posedge clk_sys);
		chk("busy", 0, write_busy_flag);
	endtask

	task automatic t_latch();
		sf({`OP_WRITE_ENABLE}, 0, 0);
		chk("latch", 1, write_latch_flag);
		sf({`OP_READ_STATUS}, 2, 0);
		chk("st0", 2'b10, rx[0][1:0]);
		chk("st1", 2'b10, rx[1][1:0]);
		chk("oe", 1, out_oe_n);
		sf({`OP_WRITE_DISABLE}, 0, 0);
		chk("latch", 0, write_latch_flag);
		sf({`OP_WRITE_ENABLE}, 0, 3);
		chk("latch", 0, write_latch_flag);
		sf({`OP_WRITE_ENABLE}, 0, 0);
		chk("latch", 1, write_latch_flag);
		sf({`OP_WRITE_DISABLE, 8'h00}, 0, 0);
		chk("latch", 1, write_latch_flag);
		sf({`OP_WRITE_DISABLE}, 0, 0);
		chk("latch", 0, write_latch_flag);
		$display("test latch done");
	endtask

	task automatic t_id();
		sf({`OP_READ_ID}, 4, 0);
		chk("id", {ID0, ID1, ID2, 8'h00}, {rx[0], rx[1], rx[2], rx[3]});
		chk("oe", 1, out_oe_n);
		$display("test id done");
	endtask

	task automatic t_read();
		for (int q = 0; q < 2; q++) begin
			beats = {};
			if (q == 0)
				sf({`OP_READ_DATA, 8'h12, 8'h34, 8'h56}, 2, 0);
			else
				sf({`OP_QUICK_READ, 8'h12, 8'h34, 8'h56, 8'h00}, 2, 0);
			chk("rd", {pat(24'h123456), pat(24'h123457)}, {rx[0], rx[1]});
			chk("radr", 24'h123456, beats[0].addr);
			chk("radr", 24'h123457, beats[1].addr);
			chk("rkind", AK_READ, beats[0].kind);
		end
		$display("test read done");
	endtask

	task automatic t_prog();
		logic [7:0]  ops[3] = '{`OP_PROGRAM_LEGACY, `OP_PROGRAM_ALTER, `OP_PROGRAM_ONES};
		array_kind_t ks[3] = '{AK_PROGRAM, AK_BITWRITE, AK_PROGRAM_ONES};
		logic [23:0] ad[3] = '{24'h00017e, 24'h00017f, 24'h000140};
		logic [7:0]  dt[3] = '{8'ha1, 8'hb2, 8'hc3};
		beats = {};
		sf({`OP_PROGRAM_LEGACY, 8'h00, 8'h01, 8'h7e, 8'ha1}, 0, 0);
		repeat (20) @(posedge clk_sys);
		chk("nobeat", 0, beats.size());
		done_dly = 40;
		for (int o = 0; o < 3; o++) begin
			sf({`OP_WRITE_ENABLE}, 0, 0);
			beats = {};
			sf({ops[o], 8'h00, 8'h01, 8'h7e, dt[0], dt[1], dt[2]}, 0, 0);
			chk("busy", 1, write_busy_flag);
			chk("latch", 0, write_latch_flag);
			wait_idle();
			chk("nbeat", 3, beats.size());
			for (int i = 0; i < 3; i++) begin
				chk("padr", ad[i], beats[i].addr);
				chk("pdat", dt[i], beats[i].data);
				chk("pkind", ks[o], beats[i].kind);
				chk("plast", i == 2, beats[i].last);
			end
		end
		$display("test program done");
	endtask

	task automatic t_erase();
		logic [23:0] a[2] = '{24'hfe1234, 24'h03ffff};
		logic [23:0] e[2] = '{24'hfe0000, 24'h020000};
		done_dly = 900;
		for (int s = 0; s < 2; s++) begin
			sf({`OP_WRITE_ENABLE}, 0, 0);
			beats = {};
			sf({`OP_BLOCK_WIPE, a[s][23:16], a[s][15:8], a[s][7:0]}, 0, 0);
			sf({`OP_READ_DATA, 8'h00, 8'h00, 8'h00}, 1, 0);
			chk("nbeat", 1, beats.size());
			sf({`OP_READ_STATUS}, 1, 0);
			chk("stbusy", 1, rx[0][0]);
			wait_idle();
			chk("eadr", e[s], beats[0].addr);
			chk("edat", 8'hff, beats[0].data);
			chk("ekind", AK_SECTOR_ERASE, beats[0].kind);
			chk("elast", 1, beats[0].last);
		end
		$display("test erase done");
	endtask

	task automatic t_status_write();
		sf({`OP_WRITE_ENABLE}, 0, 0);
		sf({`OP_WRITE_STATUS, 8'hfc}, 0, 0);
		wait_idle();
		sf({`OP_READ_STATUS}, 1, 0);
		chk("status", 8'hfc, rx[0]);
		sf({`OP_WRITE_ENABLE}, 0, 0);
		sf({`OP_WRITE_STATUS, 8'h00, 8'h00}, 0, 0);
		wait_idle();
		sf({`OP_READ_STATUS}, 1, 0);
		chk("status", 8'hfe, rx[0]);
		$display("test status write done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// the run needs about 0.75 ms; four times that means a hang
	initial begin
		#3_000_000;
		fails++;
		complete_run();
	end

	initial begin
		sys_rst   = 1'b1;
		array_rsp = '0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("latch", 0, write_latch_flag);
		t_latch();
		t_id();
		t_read();
		t_prog();
		t_erase();
		t_status_write();
		complete_run();
	end
endmodule

`default_nettype wire
